// >>> rtl/kssd_top.sv
// Key status registers, display test and segment drive behind AXI4-Lite
`timescale 1ns/1ps
module kssd_top
   import kssd_pkg::*;
#(
   parameter int unsigned SLOT_CYC   = kssd_pkg::SLOT_CYC_DEF,
   parameter int unsigned BLINK_FAST = kssd_pkg::BLINK_FAST_DEF,
   parameter int unsigned BLINK_SLOW = kssd_pkg::BLINK_SLOW_DEF
) (
   input  wire logic        aclk,          // 40 MHz clock
   input  wire logic        aresetn,       // Synchronous reset, active low
   input  wire logic [7:0]  awaddr,        // Write address
   input  wire logic        awvalid,       // Write address valid
   output logic             awready,       // Write address ready
   input  wire logic [31:0] wdata,         // Write data
   input  wire logic [3:0]  wstrb,         // Write byte strobes
   input  wire logic        wvalid,        // Write data valid
   output logic             wready,        // Write data ready
   output logic [1:0]       bresp,         // Write response
   output logic             bvalid,        // Write response valid
   input  wire logic        bready,        // Write response ready
   input  wire logic [7:0]  araddr,        // Read address
   input  wire logic        arvalid,       // Read address valid
   output logic             arready,       // Read address ready
   output logic [31:0]      rdata,         // Read data
   output logic [1:0]       rresp,         // Read response
   output logic             rvalid,        // Read data valid
   input  wire logic        rready,        // Read data ready
   input  wire logic [3:0]  key_in_n,      // Key return pins, low pressed
   output logic [7:0]       scan_line_n,   // Scan lines, low active
   output logic [7:0]       seg_drive,     // Segment drive, bit 7 is point
   output logic [7:0]       digit_type,    // Digit type setting
   output logic             key_event_interrupt_pin  // Key event, high
);
   import kssd_pkg::*;

   localparam int SW = $clog2(SLOT_CYC);
   localparam int IW = $clog2(PERIOD_SLOTS);
   localparam int LW = $clog2(LINES);
   localparam int BW = $clog2(BLINK_SLOW + 1);

   //---------------------------------------------------------------------------
   // Storage
   //---------------------------------------------------------------------------
   logic [7:0]       ctrl_q, dtype_q, pcfg_q;
   logic [31:0]      inten_q;
   logic [7:0]       segd_q [LINES];
   logic [LINES-1:0] mask_q [KEYS];
   logic [LINES-1:0] deb_q  [KEYS];
   logic [LINES-1:0] prs_q  [KEYS];
   logic [LINES-1:0] held_q [KEYS];
   logic [LINES-1:0] evt    [KEYS];
   logic             awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic             aw_held_q, w_held_q, irq_q;
   logic [1:0]       bresp_q, rresp_q;
   logic [7:0]       waddr_q;
   logic [31:0]      wdata_q, rdata_q, rd_val;
   logic [3:0]       wstrb_q;
   logic [SW-1:0]    slot_cnt_q;
   logic [IW-1:0]    slot_idx_q;
   logic [BW-1:0]    blink_cnt_q;
   logic             blink_ph_q;
   logic [3:0]       pwm_ph_q;
   logic [3:0]       key_s1_q, key_s2_q;
   logic [7:0]       scan_q;
   logic [SEGS-1:0]  seg_q;

   //---------------------------------------------------------------------------
   // Decoding helpers
   //---------------------------------------------------------------------------
   // One of four words of a group, word aligned
   function automatic logic in_group(input logic [7:0] a,
                                     input logic [7:0] base);
      in_group = (a & GROUP_MASK) == base;
   endfunction

   // Address holds a register that the given direction may reach
   function automatic logic mapped(input logic [7:0] a, input logic wr);
      mapped = (a == OFS_CTRL) || (a == OFS_DTYPE) || (a == OFS_PCFG) ||
               (a == OFS_INTEN) || (a == OFS_SEG_LO) ||
               (a == OFS_SEG_HI) || in_group(a, OFS_MASK) ||
               (!wr && (in_group(a, OFS_DEB) || in_group(a, OFS_PRS)));
   endfunction

   // Byte-lane merge of write data over the old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   logic          do_write, rd_take, rd_deb_hit, rd_prs_hit;
   logic [1:0]    rd_idx;
   logic [LW-1:0] line;
   logic          first_test, second_test, slot_end, sample;

   assign do_write   = aw_held_q && w_held_q && !bvalid_q;
   assign rd_take    = arvalid && arready_q;
   assign rd_deb_hit = rd_take && in_group(araddr, OFS_DEB);
   assign rd_prs_hit = rd_take && in_group(araddr, OFS_PRS);
   assign rd_idx     = araddr[3:2];

   //---------------------------------------------------------------------------
   // AXI4-Lite write channels
   //---------------------------------------------------------------------------
   // Address and data are held independently; both must land before bvalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         waddr_q   <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            waddr_q   <= awaddr;
         end
         if (wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(waddr_q, 1'b1) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Settings; test mode never touches them, so leaving test restores all
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q  <= CTRL_RST;
         dtype_q <= DTYPE_RST;
         pcfg_q  <= PCFG_RST;
         inten_q <= INTEN_RST;
         for (int k = 0; k < KEYS; k++) begin
            mask_q[k] <= MASK_RST;
         end
      end else if (do_write) begin
         if (waddr_q == OFS_CTRL) begin
            ctrl_q <= 8'(merge({24'h0, ctrl_q}, wdata_q, wstrb_q));
         end
         if (waddr_q == OFS_DTYPE) begin
            dtype_q <= wstrb_q[0] ? wdata_q[7:0] : dtype_q;
         end
         if (waddr_q == OFS_PCFG) begin
            pcfg_q <= wstrb_q[0] ? wdata_q[7:0] : pcfg_q;
         end
         if (waddr_q == OFS_INTEN) begin
            inten_q <= merge(inten_q, wdata_q, wstrb_q);
         end
         if (in_group(waddr_q, OFS_MASK) && wstrb_q[0]) begin
            mask_q[waddr_q[3:2]] <= wdata_q[LINES-1:0];
         end
      end
   end

   // Segment data, one byte per scan line, four lines per word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int l = 0; l < LINES; l++) begin
            segd_q[l] <= 8'h00;
         end
      end else if (do_write) begin
         for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b] && waddr_q == OFS_SEG_LO) begin
               segd_q[b] <= wdata_q[b*8 +: 8];
            end
            if (wstrb_q[b] && waddr_q == OFS_SEG_HI) begin
               segd_q[b+4] <= wdata_q[b*8 +: 8];
            end
         end
      end
   end

   //---------------------------------------------------------------------------
   // AXI4-Lite read channels
   //---------------------------------------------------------------------------
   // Read value from the current address; unmapped reads as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      if (araddr == OFS_CTRL) begin
         rd_val = {24'h0, ctrl_q};
      end else if (araddr == OFS_DTYPE) begin
         rd_val = {24'h0, dtype_q};
      end else if (araddr == OFS_PCFG) begin
         rd_val = {24'h0, pcfg_q};
      end else if (araddr == OFS_INTEN) begin
         rd_val = inten_q;
      end else if (araddr == OFS_SEG_LO) begin
         rd_val = {segd_q[3], segd_q[2], segd_q[1], segd_q[0]};
      end else if (araddr == OFS_SEG_HI) begin
         rd_val = {segd_q[7], segd_q[6], segd_q[5], segd_q[4]};
      end else if (in_group(araddr, OFS_MASK)) begin
         rd_val = {24'h0, mask_q[rd_idx]};
      end else if (in_group(araddr, OFS_DEB)) begin
         rd_val = {24'h0, deb_q[rd_idx]};
      end else if (in_group(araddr, OFS_PRS)) begin
         rd_val = {24'h0, prs_q[rd_idx]};
      end
   end

   // One read at a time; data captured before any clearing side effect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else if (rd_take) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_val;
         rresp_q   <= mapped(araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   //---------------------------------------------------------------------------
   // Scan timing
   //---------------------------------------------------------------------------
   assign line        = slot_idx_q[LW-1:0];
   assign slot_end    = slot_cnt_q == SW'(SLOT_CYC - 1);
   assign first_test  = slot_idx_q < IW'(TEST_SLOTS);
   assign second_test = (slot_idx_q >= IW'(DEB_SLOT)) &&
                        (slot_idx_q < IW'(DEB_SLOT + TEST_SLOTS));
   // Port configuration keeps gating the scan even in display test
   assign sample      = slot_end && pcfg_q[PCFG_SCAN_EN] &&
                        (first_test || second_test);

   // Slot timer and slot index over one scan period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_cnt_q <= '0;
         slot_idx_q <= '0;
      end else if (slot_end) begin
         slot_cnt_q <= '0;
         slot_idx_q <= slot_idx_q + IW'(1);
      end else begin
         slot_cnt_q <= slot_cnt_q + SW'(1);
      end
   end

   // One line low per slot, walking first to last
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_q <= 8'hFF;
      end else begin
         scan_q <= ~(8'h01 << line);
      end
   end

   // Pins are asynchronous: two flops before anything looks at them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_s1_q <= 4'hF;
         key_s2_q <= 4'hF;
      end else begin
         key_s1_q <= key_in_n;
         key_s2_q <= key_s1_q;
      end
   end

   //---------------------------------------------------------------------------
   // Key status
   //---------------------------------------------------------------------------
   // Debounce: second test still pressed, first test pressed, not held
   always_comb begin
      for (int k = 0; k < KEYS; k++) begin
         evt[k] = '0;
         if (sample && second_test && !key_s2_q[k] && prs_q[k][line] &&
             !held_q[k][line]) begin
            evt[k][line] = 1'b1;
         end
      end
   end

   // Pressed and held bits follow each test
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < KEYS; k++) begin
            prs_q[k]  <= '0;
            held_q[k] <= '0;
         end
      end else if (sample) begin
         for (int k = 0; k < KEYS; k++) begin
            prs_q[k][line] <= !key_s2_q[k];
            if (key_s2_q[k]) begin
               held_q[k][line] <= 1'b0;
            end else if (evt[k][line]) begin
               held_q[k][line] <= 1'b1;
            end
         end
      end
   end

   // Sticky debounced bits; a new event beats the clearing read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < KEYS; k++) begin
            deb_q[k] <= '0;
         end
      end else begin
         for (int k = 0; k < KEYS; k++) begin
            if (rd_deb_hit && rd_idx == 2'(k)) begin
               deb_q[k] <= evt[k];
            end else begin
               deb_q[k] <= deb_q[k] | evt[k];
            end
         end
      end
   end

   // Interrupt from unmasked debounces, dropped by any debounced read
   logic irq_set;
   always_comb begin
      irq_set = 1'b0;
      for (int k = 0; k < KEYS; k++) begin
         irq_set = irq_set | (|(evt[k] & mask_q[k]));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else if (irq_set) begin
         irq_q <= 1'b1;
      end else if (rd_deb_hit) begin
         irq_q <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // Display drive
   //---------------------------------------------------------------------------
   // Blink phase; slow select halves the rate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_q <= '0;
         blink_ph_q  <= 1'b1;
      end else if (blink_cnt_q >= BW'((ctrl_q[CTRL_BLINK_SL] ? BLINK_SLOW
                                       : BLINK_FAST) - 1)) begin
         blink_cnt_q <= '0;
         blink_ph_q  <= !blink_ph_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + BW'(1);
      end
   end

   // Shared intensity phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_ph_q <= 4'h0;
      end else begin
         pwm_ph_q <= pwm_ph_q + 4'h1;
      end
   end

   // Test forces every segment, point included, at the fixed level
   logic test;
   assign test = ctrl_q[CTRL_TEST];
   for (genvar s = 0; s < SEGS; s++) begin : g_seg
      logic [3:0] lvl;
      logic       en;
      assign lvl = test ? TEST_LEVEL : inten_q[s*LEVEL_W +: LEVEL_W];
      assign en  = test || (!ctrl_q[CTRL_SHUTDOWN] && segd_q[line][s] &&
                   (!ctrl_q[CTRL_BLINK_EN] || blink_ph_q));
      kssd_pwm u_pwm (
         .aclk    (aclk),
         .aresetn (aresetn),
         .phase   (pwm_ph_q),
         .level   (lvl),
         .enable  (en),
         .on_q    (seg_q[s])
      );
   end

   assign awready     = awready_q;
   assign wready      = wready_q;
   assign bvalid      = bvalid_q;
   assign bresp       = bresp_q;
   assign arready     = arready_q;
   assign rvalid      = rvalid_q;
   assign rdata       = rdata_q;
   assign rresp       = rresp_q;
   assign scan_line_n = scan_q;
   assign seg_drive   = seg_q;
   assign digit_type  = dtype_q;
   assign key_event_interrupt_pin = irq_q;

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   sequence s_wr_done;
      do_write ##1 bvalid_q;
   endsequence

   a_deb_read_clears: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rd_deb_hit && evt[rd_idx] == '0) |=> deb_q[$past(rd_idx)] == '0)
      else $error("debounced register not cleared by read");

   a_irq_read_drop: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rd_deb_hit && !irq_set) |=> !irq_q)
      else $error("interrupt kept after debounced read");

   a_prs_read_quiet: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rd_prs_hit && !sample && !irq_set) |=>
      (irq_q == $past(irq_q)) && (prs_q[$past(rd_idx)] ==
      $past(prs_q[rd_idx])))
      else $error("pressed read had a side effect");

   a_evt_kept: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (evt[0] != '0) |=> ((deb_q[0] & $past(evt[0])) == $past(evt[0])))
      else $error("debounce event lost");

   a_irq_masked: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!irq_q && !irq_set) |=> !irq_q)
      else $error("interrupt without unmasked event");

   a_held_once: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (sample && held_q[0][line]) |-> !evt[0][line])
      else $error("held key debounced again");

   a_test_duty: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(test) |-> seg_q[7] == ($past(pwm_ph_q) < TEST_LEVEL))
      else $error("test duty not seven sixteenths");

   a_scan_one_low: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $onehot0(~scan_q))
      else $error("more than one scan line low");

   a_bresp_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_wr_done ##0 !bready |=> bvalid_q)
      else $error("write response dropped early");
endmodule

// >>> rtl/kssd_pkg.sv
// Constants, register map and timing for the key status and display test block
//------------------------------------------------------------------------------
// How it works
// - A key completing a valid debounce sets its debounced-status bit.
// - Reading a debounced-status register returns it, then clears it.
// - Unread debounced events OR-accumulate; no order or repeat count kept.
// - Reading any of the four debounced registers drops the interrupt.
// - A held key debounces once, and again only after seen released.
// - Pressed bit shows only the latest scan test of its key.
// - Reading a pressed register clears nothing and keeps the interrupt.
// - Display test control selects normal or all-segments-on operation.
// - Test overrides settings and shutdown but leaves stored values intact.
// - Digit type and port configuration still act during display test.
// - Display test drives segments at a fixed seven-sixteenths duty.
// - Blink rate selects between one hertz and half a hertz.
// - Each segment level is off or one to fifteen sixteenths.
// - Each key is tested twice per scan period, debounce interval apart.
// - First test finding a key pressed sets its pressed-status bit.
// - Per-key mask gates the interrupt; scanning and capture continue.
// - Eight scan lines go low in turn for one slot each.
//------------------------------------------------------------------------------
package kssd_pkg;
   // Clock
   localparam int CLK_MHZ       = 40;
   localparam int CLK_HZ        = 40_000_000;
   // Scan timing, in microseconds as printed
   localparam int SLOT_US       = 200;
   localparam int TEST_US       = 1600;
   localparam int DEBOUNCE_US   = 12800;
   localparam int PERIOD_US     = 25600;
   localparam int SLOT_CYC_DEF  = SLOT_US * CLK_MHZ;
   localparam int TEST_SLOTS    = TEST_US / SLOT_US;
   localparam int DEB_SLOT      = DEBOUNCE_US / SLOT_US;
   localparam int PERIOD_SLOTS  = PERIOD_US / SLOT_US;
   // Blink rates in millihertz, half period in cycles
   localparam int BLINK_FAST_MHZ = 1000;
   localparam int BLINK_SLOW_MHZ = 500;
   localparam int BLINK_FAST_DEF = (CLK_HZ / 2 / BLINK_FAST_MHZ) * 1000;
   localparam int BLINK_SLOW_DEF = (CLK_HZ / 2 / BLINK_SLOW_MHZ) * 1000;
   // Geometry
   localparam int LINES         = 8;
   localparam int KEYS          = 4;
   localparam int SEGS          = 8;
   localparam int LEVEL_W       = 4;
   localparam logic [3:0] TEST_LEVEL = 4'h7;
   // Register byte addresses
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DTYPE   = 8'h04;
   localparam logic [7:0] OFS_PCFG    = 8'h08;
   localparam logic [7:0] OFS_INTEN   = 8'h0C;
   localparam logic [7:0] OFS_SEG_LO  = 8'h10;
   localparam logic [7:0] OFS_SEG_HI  = 8'h14;
   localparam logic [7:0] OFS_MASK    = 8'h20;
   localparam logic [7:0] OFS_DEB     = 8'h30;
   localparam logic [7:0] OFS_PRS     = 8'h40;
   localparam logic [7:0] GROUP_MASK  = 8'hF3;
   // Control fields
   localparam int CTRL_TEST     = 0;
   localparam int CTRL_SHUTDOWN = 1;
   localparam int CTRL_BLINK_EN = 2;
   localparam int CTRL_BLINK_SL = 3;
   localparam int PCFG_SCAN_EN  = 0;
   // Values after reset
   localparam logic [7:0]  CTRL_RST  = 8'h02;
   localparam logic [7:0]  DTYPE_RST = 8'h00;
   localparam logic [7:0]  PCFG_RST  = 8'h00;
   localparam logic [31:0] INTEN_RST = 32'h0000_0000;
   localparam logic [7:0]  MASK_RST  = 8'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/kssd_pwm.sv
// One segment's sixteen-step intensity gate
`timescale 1ns/1ps
module kssd_pwm (
   input  wire logic       aclk,     // System clock
   input  wire logic       aresetn,  // Synchronous reset, active low
   input  wire logic [3:0] phase,    // Shared sixteen-step phase
   input  wire logic [3:0] level,    // Zero is off, n is n/16
   input  wire logic       enable,   // Segment wanted lit
   output logic            on_q      // Registered drive
);
   // Lit for level phases out of sixteen; level zero never lights
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_q <= 1'b0;
      end else begin
         on_q <= enable && (phase < level);
      end
   end
endmodule

// >>> test/kssd_keys.sv
// Key matrix model: one switch per key and scan line
`timescale 1ns/1ps
module kssd_keys (
   input  wire logic [7:0]  scan_line_n,  // Scan lines, low active
   input  wire logic [31:0] held,         // Key k, line l at bit 8k+l
   output logic [3:0]       key_in_n      // Returns, pulled up
);
   // Pull-up wins unless a closed switch meets a low line
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         key_in_n[k] = ~|(held[8*k+:8] & ~scan_line_n);
      end
   end
endmodule

// >>> test/keyscan_status_display_test_tb_top.sv
// Bench: key status, display test and intensity over AXI4-Lite
`timescale 1ns/1ps
module keyscan_status_display_test_tb_top;
   import kssd_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 0, araddr = 0, scan_line_n, seg_drive, digit_type;
   logic [31:0] wdata = 0, rdata, rd_q, held = 0;
   logic [1:0] bresp, rresp, rs_q;
   logic [3:0] key_in_n;
   logic irq;
   int bad_count = 0, cmp_count = 0, c [8];
   // Short counts keep one key period at 2048 cycles
   kssd_top #(.SLOT_CYC(16), .BLINK_FAST(8), .BLINK_SLOW(16)) uut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .key_in_n(key_in_n),
      .scan_line_n(scan_line_n), .seg_drive(seg_drive),
      .digit_type(digit_type), .key_event_interrupt_pin(irq));
   kssd_keys keys (.scan_line_n(scan_line_n), .held(held),
      .key_in_n(key_in_n));
   initial forever #12.5 aclk = ~aclk;
   task test_done;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // Address and data offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (awvalid | wvalid);
      do @(posedge aclk); while (!bvalid);
      bready <= 0;
      chk("bresp", RESP_OKAY, bresp);
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rd_q = rdata;
      rs_q = rresp;
      rready <= 0;
   endtask
   task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(n, e, rd_q);
   endtask
   // Lit cycles per segment over n cycles; settle lets blink steady
   task cnt(input int n);
      c = '{default: 0};
      repeat (20) @(posedge aclk);
      repeat (n) begin
         @(posedge aclk);
         for (int i = 0; i < 8; i++) c[i] += seg_drive[i];
      end
   endtask
   task periods(input int n);
      repeat (n * 2048) @(posedge aclk);
   endtask
   // Watchdog, well past the expected 13k cycles
   initial begin
      #1500000;
      bad_count++;
      test_done;
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      wr(OFS_PCFG, 1);
      wr(OFS_MASK, 8'hFF);
      held <= 32'h4;
      periods(2);
      chk("irq", 1, irq);
      rdc("prs a", OFS_PRS, 32'h4);
      chk("irq kept", 1, irq);
      rdc("deb a", OFS_DEB, 32'h4);
      chk("irq drop", 0, irq);
      rdc("deb clear", OFS_DEB, 0);
      periods(2);
      chk("irq held", 0, irq);
      rdc("deb held", OFS_DEB, 0);
      held <= 32'h2200;
      periods(2);
      rdc("prs a off", OFS_PRS, 0);
      chk("irq masked", 0, irq);
      for (int k = 0; k < 4; k++)
         rdc("deb", OFS_DEB + 8'(4*k),
             k == 1 ? 32'h22 : 0);
      chk("scan one low", 1, $onehot(~scan_line_n));
      $display("key tests done");
      wr(OFS_DTYPE, 8'hA5);
      wr(OFS_INTEN, 32'hF0);
      wr(OFS_SEG_LO, '1);
      wr(OFS_SEG_HI, '1);
      wr(OFS_CTRL, 3);
      cnt(16);
      for (int i = 0; i < 8; i++) chk("duty", 7, c[i]);
      chk("dtype", 8'hA5, digit_type);
      wr(OFS_CTRL, 2);
      cnt(16);
      chk("shutdown", 0, c[1]);
      wr(OFS_CTRL, 0);
      cnt(16);
      chk("off", 0, c[0]);
      chk("full", 15, c[1]);
      // Fast blink: lit half of each phase turn; slow: 15 per 32 cycles
      wr(OFS_CTRL, 32'h4);
      cnt(64);
      chk("blink fast", 32, c[1]);
      wr(OFS_CTRL, 32'hC);
      cnt(64);
      chk("blink slow", 30, c[1]);
      wr(OFS_CTRL, 0);
      rdc("inten", OFS_INTEN, 32'hF0);
      rd(8'h80);
      chk("unmapped", RESP_SLVERR, rs_q);
      $display("display tests done");
      test_done;
   end
endmodule
